// >>> chsw_pkg.sv
// constants and carrier types for the charger switch control block
package chsw_pkg;
    localparam int CLK_NS = 10;
    localparam int BBM_NS = 7500;
    localparam logic [9:0] BBM_CYC = 10'((BBM_NS + CLK_NS - 1) / CLK_NS);
    localparam int MIN_OFF_NS = 300;
    localparam logic [7:0] MIN_OFF_CYC = 8'((MIN_OFF_NS + CLK_NS - 1) / CLK_NS);
    localparam int SW_PERIOD_NS = 2500;
    localparam logic [7:0] NOM_OFF_CYC = 8'((SW_PERIOD_NS / 2) / CLK_NS);
    localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3f;
    localparam logic [7:0] CMD_CHARGER_CFG = 8'h12;
    localparam int LIMIT_LSB = 7;
    localparam int LIMIT_W = 6;
    localparam logic [5:0] LIMIT_RST = 6'h00;
    localparam int CFG_INHIBIT_BIT = 0;
    localparam int CFG_HOT_STOP_BIT = 1;
    localparam int CFG_POR_BIT = 2;
    localparam logic CFG_INHIBIT_RST = 1'b0;
    localparam logic CFG_HOT_STOP_RST = 1'b1;
    localparam int LOOP_MV_PER_LSB = 10;
    localparam int CLAMP_MV = 300;
    localparam logic [7:0] CLAMP_LSB = 8'(CLAMP_MV / LOOP_MV_PER_LSB);

    typedef struct packed {
        logic adapter;
        logic diff_low;
        logic dropout;
        logic t_over;
        logic t_cold;
        logic t_hot;
        logic t_under;
        logic min_ctl;
        logic peak;
        logic ovc;
        logic zero;
    } chsw_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [15:0] data;
    } chsw_cmd_t;

    typedef struct packed {
        logic over;
        logic cold;
        logic hot;
        logic under;
    } chsw_flags_t;

    typedef enum logic [1:0] {
        PATH_SRC = 2'b00,
        PATH_BREAK = 2'b01,
        PATH_BAT = 2'b10,
        PATH_DOWN = 2'b11
    } chsw_path_e;

    typedef enum logic [1:0] {
        CYC_WAIT = 2'b00,
        CYC_ON = 2'b01,
        CYC_OFF = 2'b10
    } chsw_cyc_e;
endpackage

// >>> chsw_sync.sv
// two-stage synchroniser for all comparator and pin inputs
`timescale 1ns/1ps
module chsw_sync (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire chsw_pkg::chsw_pins_t pins_raw,
    output chsw_pkg::chsw_pins_t pins
);
    typedef struct packed {
        chsw_pkg::chsw_pins_t meta;
        chsw_pkg::chsw_pins_t stable;
    } chsw_sync_t;

    chsw_sync_t st;
    chsw_sync_t next_st;

    always_comb begin
        next_st.meta = pins_raw;
        next_st.stable = st.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pins = st.stable;
endmodule

// >>> chsw_cycle.sv
// step-down converter cycle state machine driven by four comparators
`timescale 1ns/1ps
module chsw_cycle (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic min_ctl,
    input wire logic peak,
    input wire logic ovc,
    input wire logic zero,
    input wire logic dropout,
    output logic high_side_on,
    output logic low_side_on
);
    typedef struct packed {
        chsw_pkg::chsw_cyc_e state;
        logic [7:0] off_cnt;
        logic hs;
        logic ls;
    } chsw_cyc_t;

    chsw_cyc_t st;
    chsw_cyc_t next_st;
    logic start_ok;
    logic [7:0] off_load;

    always_comb begin
        next_st = st;
        start_ok = enable && min_ctl && !ovc && (st.off_cnt == 8'h00); // R12 R15 R17
        // dropout shortens the off-time to the floor, else half the nominal period
        off_load = dropout ? chsw_pkg::MIN_OFF_CYC - 8'h01
                           : chsw_pkg::NOM_OFF_CYC - 8'h01; // R17 R18
        if (st.off_cnt != 8'h00) begin
            next_st.off_cnt = st.off_cnt - 8'h01; // R21
        end
        unique case (st.state)
            chsw_pkg::CYC_WAIT: begin
                if (start_ok) begin
                    next_st.state = chsw_pkg::CYC_ON; // R13
                end
            end
            chsw_pkg::CYC_ON: begin
                if (!enable || peak || ovc) begin
                    next_st.state = enable ? chsw_pkg::CYC_OFF : chsw_pkg::CYC_WAIT; // R14 R15
                    next_st.off_cnt = off_load; // R17
                end
            end
            chsw_pkg::CYC_OFF: begin
                if (!enable || zero) begin
                    next_st.state = chsw_pkg::CYC_WAIT; // R16
                end else if (start_ok) begin
                    next_st.state = chsw_pkg::CYC_ON;
                end
            end
            default: next_st.state = chsw_pkg::CYC_WAIT;
        endcase
        next_st.hs = (next_st.state == chsw_pkg::CYC_ON); // R13 R14
        next_st.ls = (next_st.state == chsw_pkg::CYC_OFF); // R14 R16
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign high_side_on = st.hs;
    assign low_side_on = st.ls;

    // helper: cycles the high side has been off
    logic [7:0] gap;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gap <= 8'hff;
        end else if (st.hs) begin
            gap <= 8'h00;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_NO_START_LOW_MIN: assert property (!min_ctl && !st.hs |=> !st.hs) // R12
        else $error("cycle started with control point low");
    AST_START_DRIVES: assert property ($rose(st.hs) |-> !st.ls) // R13
        else $error("low side on at cycle start");
    AST_PEAK_ENDS: assert property (st.hs && peak && enable |=> !st.hs && st.ls) // R14
        else $error("peak current did not end on-time");
    AST_OVC_HOLD: assert property (ovc && !st.hs |=> !st.hs) // R15
        else $error("cycle started during overcurrent");
    AST_ZERO_OFF: assert property (st.ls && zero |=> !st.hs && !st.ls) // R16
        else $error("zero current did not turn both switches off");
    AST_MIN_OFF: assert property ($rose(st.hs) |-> gap >= chsw_pkg::MIN_OFF_CYC) // R17
        else $error("off-time shorter than minimum");
endmodule

// >>> chsw_top.sv
// charger switch control: temperature flags, power path, command words, converter
// Operation
// R1 - overrange: open sensor, reset charger, battery absent
// R2 - cold flag set above 30k, charging unaffected
// R3 - hot flag below 3k, latched, cleared by removal/reset
// R4 - hot stops charge unless hot-stop off or underrange
// R5 - underrange flag below 500 ohm, shorted sense
// R6 - each temperature flag evaluated independently
// R7 - fixed-resistor packs must present correct resistances
// R8 - adapter present: release adapter-ok, source switch on
// R9 - load switch off while charging
// R10 - adapter removal: source off, load on 7.5us later
// R11 - input-battery difference low: load on, power down
// R12 - no new cycle while control point low
// R13 - cycle starts high side on, rectifier off
// R14 - peak current ends on-time, rectifier on
// R15 - overcurrent ends on-time, blocks restart until low
// R16 - zero current turns both switches off
// R17 - off-time at least 300ns every cycle
// R18 - nominal 400kHz switching outside dropout
// R19 - lowest loop controls, others clamped 0.3V above
// R20 - input limit from bits 7..12, rest ignored
// R21 - comparators synchronised, intervals counted in cycles
`timescale 1ns/1ps
module chsw_top (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire chsw_pkg::chsw_pins_t pins_raw,
    input wire chsw_pkg::chsw_cmd_t cmd,
    input wire logic [7:0] voltage_loop,
    input wire logic [7:0] charge_loop,
    input wire logic [7:0] input_loop,
    output logic adapter_ok_out_o,
    output logic adapter_ok_out_oe,
    output logic source_switch_drive,
    output logic load_switch_drive,
    output logic power_down,
    output logic charge_enable,
    output logic battery_present,
    output logic charger_reset,
    output chsw_pkg::chsw_flags_t temp_flags,
    output logic [5:0] input_limit_code,
    output logic [7:0] lowest_loop_control,
    output logic [7:0] loop_clamp_level,
    output logic high_side_on,
    output logic low_side_on
);
    typedef struct packed {
        chsw_pkg::chsw_path_e path;
        logic [9:0] bbm_cnt;
        logic src;
        logic load;
        logic pdn;
        logic adapter_ok_out_pull;
        logic hot;
        logic [5:0] limit;
        logic hot_stop;
        logic inhibit;
        logic chg_rst;
        logic chg_en;
        logic [7:0] lowest;
        logic [7:0] clamp;
    } chsw_top_t;

    chsw_top_t st;
    chsw_top_t next_st;
    chsw_pkg::chsw_pins_t pins;
    logic por_cmd;
    logic charger_rst;
    logic hot_block;
    logic [7:0] low_vc;
    logic [8:0] clamp_sum;

    // raw comparator levels are asynchronous to sys_clk
    chsw_sync chsw_sync_inst ( // R21
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pins_raw(pins_raw),
        .pins(pins)
    );

    always_comb begin
        next_st = st;
        por_cmd = cmd.valid && (cmd.code == chsw_pkg::CMD_CHARGER_CFG)
            && cmd.data[chsw_pkg::CFG_POR_BIT];
        // an open sensor means no battery, so the charger falls back to reset
        charger_rst = pins.t_over || por_cmd; // R1
        next_st.chg_rst = charger_rst;

        if (cmd.valid && !charger_rst) begin
            if (cmd.code == chsw_pkg::CMD_INPUT_LIMIT) begin
                next_st.limit = cmd.data[chsw_pkg::LIMIT_LSB +: chsw_pkg::LIMIT_W]; // R20
            end
            if (cmd.code == chsw_pkg::CMD_CHARGER_CFG) begin
                next_st.inhibit = cmd.data[chsw_pkg::CFG_INHIBIT_BIT];
                next_st.hot_stop = cmd.data[chsw_pkg::CFG_HOT_STOP_BIT]; // R4
            end
        end

        if (charger_rst) begin
            next_st.limit = chsw_pkg::LIMIT_RST; // R1
            next_st.inhibit = chsw_pkg::CFG_INHIBIT_RST;
            next_st.hot_stop = chsw_pkg::CFG_HOT_STOP_RST;
            next_st.hot = 1'b0; // R3
        end
        // a new hot reading wins over a clear in the same cycle
        if (pins.t_hot) begin
            next_st.hot = 1'b1; // R3 R6
        end

        unique case (st.path)
            chsw_pkg::PATH_SRC: begin
                if (pins.diff_low) begin
                    next_st.path = chsw_pkg::PATH_DOWN; // R11
                end else if (!pins.adapter) begin
                    next_st.path = chsw_pkg::PATH_BREAK; // R10
                    next_st.bbm_cnt = chsw_pkg::BBM_CYC - 10'h001;
                end
            end
            chsw_pkg::PATH_BREAK: begin
                // both switches off while the source gate discharges
                if (pins.diff_low) begin
                    next_st.path = chsw_pkg::PATH_DOWN; // R11
                end else if (pins.adapter) begin
                    next_st.path = chsw_pkg::PATH_SRC; // R8
                end else if (st.bbm_cnt == 10'h000) begin
                    next_st.path = chsw_pkg::PATH_BAT; // R10
                end else begin
                    next_st.bbm_cnt = st.bbm_cnt - 10'h001; // R21
                end
            end
            chsw_pkg::PATH_BAT: begin
                if (pins.diff_low) begin
                    next_st.path = chsw_pkg::PATH_DOWN; // R11
                end else if (pins.adapter) begin
                    next_st.path = chsw_pkg::PATH_SRC; // R8
                end
            end
            chsw_pkg::PATH_DOWN: begin
                if (!pins.diff_low) begin
                    next_st.path = pins.adapter ? chsw_pkg::PATH_SRC : chsw_pkg::PATH_BAT;
                end
            end
        endcase

        next_st.src = (next_st.path == chsw_pkg::PATH_SRC); // R8 R10 R11
        next_st.load = (next_st.path == chsw_pkg::PATH_BAT)
            || (next_st.path == chsw_pkg::PATH_DOWN); // R9 R10 R11
        next_st.pdn = (next_st.path == chsw_pkg::PATH_DOWN); // R11
        next_st.adapter_ok_out_pull = !pins.adapter; // R8

        // cold is deliberately absent from the enable term
        hot_block = st.hot && st.hot_stop && !pins.t_under; // R4 R2
        next_st.chg_en = (st.path == chsw_pkg::PATH_SRC)
            && (next_st.path == chsw_pkg::PATH_SRC)
            && pins.adapter && !pins.t_over && !st.inhibit
            && !hot_block && !charger_rst; // R1 R4 R9

        // digital image of the lowest-voltage clamp
        low_vc = voltage_loop;
        if (charge_loop < low_vc) begin
            low_vc = charge_loop; // R19
        end
        if (input_loop < low_vc) begin
            low_vc = input_loop; // R19
        end
        clamp_sum = {1'b0, low_vc} + {1'b0, chsw_pkg::CLAMP_LSB};
        next_st.lowest = low_vc;
        next_st.clamp = clamp_sum[8] ? 8'hff : clamp_sum[7:0]; // R19
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st.path <= chsw_pkg::PATH_BAT;
            st.bbm_cnt <= 10'h000;
            st.src <= 1'b0;
            st.load <= 1'b1;
            st.pdn <= 1'b0;
            st.adapter_ok_out_pull <= 1'b1;
            st.hot <= 1'b0;
            st.limit <= chsw_pkg::LIMIT_RST;
            st.hot_stop <= chsw_pkg::CFG_HOT_STOP_RST;
            st.inhibit <= chsw_pkg::CFG_INHIBIT_RST;
            st.chg_rst <= 1'b0;
            st.chg_en <= 1'b0;
            st.lowest <= 8'h00;
            st.clamp <= 8'h00;
        end else begin
            st <= next_st;
        end
    end

    chsw_cycle chsw_cycle_inst (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .enable(st.chg_en),
        .min_ctl(pins.min_ctl),
        .peak(pins.peak),
        .ovc(pins.ovc),
        .zero(pins.zero),
        .dropout(pins.dropout),
        .high_side_on(high_side_on),
        .low_side_on(low_side_on)
    );

    // open drain: pulled low only while no adapter is seen
    assign adapter_ok_out_o = 1'b0;
    assign adapter_ok_out_oe = st.adapter_ok_out_pull; // R8
    assign source_switch_drive = st.src;
    assign load_switch_drive = st.load;
    assign power_down = st.pdn;
    assign charge_enable = st.chg_en;
    assign battery_present = !pins.t_over; // R1
    assign charger_reset = st.chg_rst;
    assign temp_flags = {pins.t_over, pins.t_cold, st.hot, pins.t_under}; // R1 R2 R3 R5 R6
    assign input_limit_code = st.limit;
    assign lowest_loop_control = st.lowest;
    assign loop_clamp_level = st.clamp;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_break_start;
        $fell(st.src) && (st.path == chsw_pkg::PATH_BREAK);
    endsequence

    sequence s_limit_write;
        cmd.valid && (cmd.code == chsw_pkg::CMD_INPUT_LIMIT) && !charger_rst;
    endsequence

    AST_OVER_RESETS: assert property (pins.t_over |=> !st.chg_en && st.chg_rst // R1
        && st.limit == chsw_pkg::LIMIT_RST)
        else $error("overrange did not reset the charger");
    AST_OVER_ABSENT: assert property (pins.t_over |-> !battery_present) // R1
        else $error("battery present while sensor open");
    AST_COLD_ONLY: assert property (pins.t_cold && !pins.t_over && !pins.t_hot // R2
        && !st.hot && !por_cmd && st.chg_en && (next_st.path == chsw_pkg::PATH_SRC)
        && pins.adapter && !st.inhibit |=> st.chg_en)
        else $error("cold flag stopped charging");
    AST_HOT_LATCH: assert property (st.hot && !charger_rst |=> st.hot) // R3
        else $error("hot flag released without reset");
    AST_HOT_SETS: assert property (pins.t_hot |=> temp_flags.hot) // R3
        else $error("hot flag not set");
    AST_HOT_STOP: assert property (st.hot && st.hot_stop && !pins.t_under |=> !st.chg_en) // R4
        else $error("charging while hot");
    AST_MULTI_FLAG: assert property (pins.t_hot && pins.t_under // R5 R6
        |-> temp_flags.under ##1 temp_flags.hot)
        else $error("hot and underrange not both set");
    AST_ADAPTER_OK_OUT_REL: assert property (st.path == chsw_pkg::PATH_SRC |-> !adapter_ok_out_oe) // R8
        else $error("adapter-ok pulled low with adapter present");
    AST_LOAD_OFF: assert property (st.chg_en |-> !st.load && st.src) // R9
        else $error("load switch on while charging");
    AST_BBM: assert property (s_break_start |-> !st.load [*8]) // R10
        else $error("load switch on too soon after source off");
    AST_BBM_END: assert property (st.path == chsw_pkg::PATH_BREAK // R10
        && st.bbm_cnt == 10'h000 && !pins.adapter && !pins.diff_low |=> st.load && !st.src)
        else $error("load switch not on at end of break delay");
    AST_DIFF_LOW: assert property (pins.diff_low |=> st.pdn && st.load && !st.src) // R11
        else $error("low input difference did not power down");
    AST_LIMIT: assert property (s_limit_write |=> st.limit // R20
        == $past(cmd.data[chsw_pkg::LIMIT_LSB +: chsw_pkg::LIMIT_W]))
        else $error("input limit word not taken from bits 7..12");
    AST_LOWEST: assert property (##1 (st.lowest <= $past(voltage_loop)) // R19
        && (st.lowest <= $past(charge_loop)) && (st.lowest <= $past(input_loop))
        && ((st.lowest == $past(voltage_loop)) || (st.lowest == $past(charge_loop))
        || (st.lowest == $past(input_loop))))
        else $error("control point not the lowest loop");
endmodule

// >>> chsw_plant.sv
// model of the power stage, adapter sense and battery pack thermistor
`timescale 1ns/1ps
module chsw_plant (
    input wire logic sys_clk,
    input wire logic adapter,
    input wire logic diff_low,
    input wire logic dropout,
    input wire logic [31:0] r_ohm,
    input wire logic min_ctl,
    input wire logic ovc,
    input wire logic [7:0] peak_len,
    input wire logic [7:0] zero_len,
    input wire logic high_side_on,
    input wire logic low_side_on,
    output chsw_pkg::chsw_pins_t pins_raw
);
    logic [7:0] on_cnt;
    logic [7:0] off_cnt;
    logic zflag;

    initial begin
        on_cnt = 8'h00;
        off_cnt = 8'h00;
        zflag = 1'b0;
    end

    // inductor current: rises while high side conducts, decays while rectifier conducts
    always @(posedge sys_clk) begin
        on_cnt <= high_side_on ? on_cnt + 8'h01 : 8'h00;
        off_cnt <= !low_side_on ? 8'h00 : (off_cnt == 8'hff ? off_cnt : off_cnt + 8'h01);
        // current stays at zero until the high side conducts again
        zflag <= high_side_on ? 1'b0 : (zflag | (low_side_on && off_cnt >= zero_len));
    end

    always_comb begin
        pins_raw.adapter = adapter;
        pins_raw.diff_low = diff_low;
        pins_raw.dropout = dropout;
        // pack presents its resistance; each class compared on its own
        pins_raw.t_over = r_ohm > 32'd100000;
        pins_raw.t_cold = r_ohm > 32'd30000;
        pins_raw.t_hot = r_ohm < 32'd3000;
        pins_raw.t_under = r_ohm < 32'd500;
        pins_raw.min_ctl = min_ctl;
        pins_raw.peak = high_side_on && on_cnt >= peak_len;
        pins_raw.ovc = ovc;
        pins_raw.zero = zflag;
    end
endmodule

// >>> charger_switch_control_bench.sv
// self-checking testbench for the charger switch control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module charger_switch_control_bench;
    logic sys_clk;
    logic rst_b;
    logic adapter, diff_low, dropout, min_ctl, ovc;
    logic [31:0] r_ohm;
    logic [7:0] peak_len, zero_len;
    logic [7:0] voltage_loop, charge_loop, input_loop;
    chsw_pkg::chsw_cmd_t cmd;
    chsw_pkg::chsw_pins_t pins_raw;
    chsw_pkg::chsw_flags_t temp_flags;
    logic adapter_ok_out_o, adapter_ok_out_oe, source_switch_drive, load_switch_drive;
    logic power_down, charge_enable, battery_present, charger_reset;
    logic [5:0] input_limit_code;
    logic [7:0] lowest_loop_control, loop_clamp_level;
    logic high_side_on, low_side_on;
    int n_mismatch;
    int samples_checked;
    int n;
    logic seen;
    logic [15:0] words [5] = '{16'h0f80, 16'hf07f, 16'h1000, 16'h0080, 16'hffff};

    chsw_top chsw_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .pins_raw(pins_raw), .cmd(cmd),
        .voltage_loop(voltage_loop), .charge_loop(charge_loop), .input_loop(input_loop),
        .adapter_ok_out_o(adapter_ok_out_o), .adapter_ok_out_oe(adapter_ok_out_oe),
        .source_switch_drive(source_switch_drive), .load_switch_drive(load_switch_drive),
        .power_down(power_down), .charge_enable(charge_enable),
        .battery_present(battery_present), .charger_reset(charger_reset),
        .temp_flags(temp_flags), .input_limit_code(input_limit_code),
        .lowest_loop_control(lowest_loop_control), .loop_clamp_level(loop_clamp_level),
        .high_side_on(high_side_on), .low_side_on(low_side_on));

    chsw_plant chsw_plant_inst (.sys_clk(sys_clk), .adapter(adapter), .diff_low(diff_low),
        .dropout(dropout), .r_ohm(r_ohm), .min_ctl(min_ctl), .ovc(ovc), .peak_len(peak_len),
        .zero_len(zero_len), .high_side_on(high_side_on), .low_side_on(low_side_on),
        .pins_raw(pins_raw));

    always #5 sys_clk = ~sys_clk;

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // one strobe, then an idle edge so back-to-back calls never collide
    task automatic send(input logic [7:0] code, input logic [15:0] data);
        cmd <= '{valid: 1'b1, code: code, data: data};
        step(1);
        cmd.valid <= 1'b0;
        step(1);
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return source_switch_drive;
            1: return load_switch_drive;
            2: return high_side_on;
            default: return low_side_on;
        endcase
    endfunction

    // n returns the number of edges until the output shows v
    task automatic wait_until(input int k, input logic v, output int cnt);
        cnt = 0;
        while (pick(k) !== v) begin
            step(1);
            cnt++;
            if (cnt > 2000) begin
                n_mismatch++;
                $display("ERROR wait on output %0d expected %0h never seen", k, v);
                tally_and_finish();
            end
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        {adapter, diff_low, dropout, ovc} = 4'h0;
        min_ctl = 1'b1;
        r_ohm = 32'd10000;
        peak_len = 8'd20;
        zero_len = 8'hff;
        {voltage_loop, charge_loop, input_loop} = 24'h0;
        cmd = '0;
        n_mismatch = 0;
        samples_checked = 0;
        step(12);
        rst_b <= 1'b1;
        step(4);
        `CHK("adapter_ok_oe", 1'b1, adapter_ok_out_oe)
        `CHK("adapter_ok_o", 1'b0, adapter_ok_out_o)
        foreach (words[i]) begin
            send(chsw_pkg::CMD_INPUT_LIMIT, words[i]);
            `CHK("input_limit_code", words[i][12:7], input_limit_code)
        end
        send(8'h14, 16'h0000);
        `CHK("limit_other_code", 6'h3f, input_limit_code)
        adapter <= 1'b1;
        wait_until(0, 1'b1, n);
        `CHK("load_switch_chg", 1'b0, load_switch_drive)
        `CHK("adapter_ok_oe_on", 1'b0, adapter_ok_out_oe)
        step(3);
        `CHK("charge_enable", 1'b1, charge_enable)
        wait_until(2, 1'b1, n);
        `CHK("ls_at_start", 1'b0, low_side_on)
        wait_until(2, 1'b0, n);
        `CHK("ls_after_peak", 1'b1, low_side_on)
        wait_until(2, 1'b1, n);
        `CHK("off_time_nominal", int'(chsw_pkg::NOM_OFF_CYC), n)
        dropout <= 1'b1;
        wait_until(2, 1'b0, n);
        wait_until(2, 1'b1, n);
        wait_until(2, 1'b0, n);
        wait_until(2, 1'b1, n);
        `CHK("off_time_min", 1'b1, n >= int'(chsw_pkg::MIN_OFF_CYC))
        dropout <= 1'b0;
        zero_len <= 8'd10;
        wait_until(2, 1'b0, n);
        wait_until(3, 1'b0, n);
        `CHK("hs_at_zero", 1'b0, high_side_on)
        zero_len <= 8'hff;
        wait_until(2, 1'b1, n);
        ovc <= 1'b1;
        wait_until(2, 1'b0, n);
        `CHK("ovc_ends_on", 1'b1, n < 8)
        step(300);
        `CHK("ovc_blocks", 1'b0, high_side_on)
        ovc <= 1'b0;
        wait_until(2, 1'b1, n);
        min_ctl <= 1'b0;
        wait_until(2, 1'b0, n);
        step(300);
        `CHK("minctl_blocks", 1'b0, high_side_on)
        min_ctl <= 1'b1;
        wait_until(2, 1'b1, n);
        r_ohm <= 32'd2000;
        step(5);
        `CHK("hot_set", 4'b0010, temp_flags)
        `CHK("hot_stops", 1'b0, charge_enable)
        r_ohm <= 32'd10000;
        step(5);
        `CHK("hot_latched", 4'b0010, temp_flags)
        send(chsw_pkg::CMD_CHARGER_CFG, 16'h0000);
        step(1);
        `CHK("hot_stop_off", 1'b1, charge_enable)
        send(chsw_pkg::CMD_CHARGER_CFG, 16'h0002);
        step(1);
        `CHK("hot_stop_on", 1'b0, charge_enable)
        r_ohm <= 32'd450;
        step(5);
        `CHK("hot_and_under", 4'b0011, temp_flags)
        `CHK("under_allows", 1'b1, charge_enable)
        r_ohm <= 32'd200000;
        seen = 1'b0;
        repeat (6) begin
            step(1);
            seen = seen | (charger_reset === 1'b1);
        end
        `CHK("charger_reset", 1'b1, seen)
        `CHK("battery_absent", 1'b0, battery_present)
        `CHK("hot_cleared", 1'b0, temp_flags.hot)
        `CHK("limit_restored", 6'h00, input_limit_code)
        send(chsw_pkg::CMD_INPUT_LIMIT, 16'h0f80);
        `CHK("limit_refused", 6'h00, input_limit_code)
        r_ohm <= 32'd50000;
        step(5);
        `CHK("cold_flag", 4'b0100, temp_flags)
        `CHK("cold_charges", 1'b1, charge_enable)
        `CHK("battery_back", 1'b1, battery_present)
        send(chsw_pkg::CMD_CHARGER_CFG, 16'h0003);
        step(1);
        `CHK("inhibit_stops", 1'b0, charge_enable)
        send(chsw_pkg::CMD_CHARGER_CFG, 16'h0002);
        step(1);
        `CHK("inhibit_clear", 1'b1, charge_enable)
        r_ohm <= 32'd2000;
        step(5);
        r_ohm <= 32'd10000;
        send(chsw_pkg::CMD_INPUT_LIMIT, 16'h0f80);
        send(chsw_pkg::CMD_CHARGER_CFG, 16'h0004);
        step(1);
        `CHK("reset_cmd_hot", 1'b0, temp_flags.hot)
        `CHK("reset_cmd_limit", 6'h00, input_limit_code)
        voltage_loop <= 8'd80;
        charge_loop <= 8'd50;
        input_loop <= 8'd120;
        step(3);
        `CHK("lowest_loop", 8'd50, lowest_loop_control)
        `CHK("clamp_level", 8'd80, loop_clamp_level)
        voltage_loop <= 8'd240;
        charge_loop <= 8'd250;
        input_loop <= 8'd245;
        step(3);
        `CHK("lowest_loop_hi", 8'd240, lowest_loop_control)
        `CHK("clamp_saturate", 8'hff, loop_clamp_level)
        // adapter returning inside the break window must fall back to the source path
        adapter <= 1'b0;
        wait_until(0, 1'b0, n);
        step(100);
        adapter <= 1'b1;
        wait_until(0, 1'b1, n);
        `CHK("abort_load_off", 1'b0, load_switch_drive)
        adapter <= 1'b0;
        wait_until(0, 1'b0, n);
        `CHK("break_load_off", 1'b0, load_switch_drive)
        `CHK("adapter_ok_pull", 1'b1, adapter_ok_out_oe)
        wait_until(1, 1'b1, n);
        `CHK("break_delay", int'(chsw_pkg::BBM_CYC), n)
        adapter <= 1'b1;
        wait_until(0, 1'b1, n);
        diff_low <= 1'b1;
        step(5);
        `CHK("pd_power_down", 1'b1, power_down)
        `CHK("pd_load_on", 1'b1, load_switch_drive)
        `CHK("pd_source_off", 1'b0, source_switch_drive)
        tally_and_finish();
    end
endmodule
